// file: scc_channel.sv
// One serial channel: async, clocked sync and smart card framing.
// Assumes pins come from outside the clock domain and are synchronised.
//
// Summary of operation
// - Receive shifter fills, then moves to holding
// - Receive holding is 8 bits, read-only, zero
// - Writes to receive holding are ignored
// - Shifter free for next frame right away
// - Empty shifter loads holding and starts sending
// - Pending data loads back to back, no gap
// - Transmit holding always read/write; resets to FF
// - Transmitter and receiver run independently
// - Async: 7/8 bits, 1/2 stops, parity
// - Async flags parity, overrun and framing errors
// - Serial input level readable by software
// - Sync: 8 bits, only overrun detected
// - LSB/MSB first, async 7-bit always LSB
// - Four interrupt requests leave the channel
// - Empty and full also trigger transfers
// - Internal or external clock, not smart card
// - Smart card: parity error drives error signal
// - Smart card: error signal causes resend
// - Smart card: direct and inverse conventions
// - Clock pin two-way, data in, data out
// - 7-bit mode drops holding bit 7
// - Only first stop checked; low second restarts
// - Parity select: 0 even, 1 odd
// - Multiprocessor format suppresses parity
`timescale 1ns/1ps
`default_nettype none

module scc_channel
(
	input  wire logic       clock,
	input  wire logic       rst,
	input  wire logic [2:0] reg_addr,
	input  wire logic [7:0] reg_wdata,
	input  wire logic       reg_wr,
	input  wire logic       reg_rd,
	output logic      [7:0] reg_rdata,
	input  wire logic       rxd_pin,
	output logic            txd_pin,
	input  wire logic       sck_in,
	output logic            sck_out,
	output logic            sck_oe,
	output logic            irq_tx_end,
	output logic            irq_tx_empty,
	output logic            irq_rx_full,
	output logic            irq_rx_err,
	output logic            dma_tx_req,
	output logic            dma_rx_req
);

	// ----------------------------------------------------------------
	// Frame builder and helpers
	// ----------------------------------------------------------------
	function automatic logic [7:0] bit_rev(input logic [7:0] v);
		logic [7:0] r;
		r = 8'h00;
		for (int i = 0; i < 8; i++)
			r[i] = v[7 - i];
		return r;
	endfunction

	// Returns {length, line bits}; bit 0 goes out first
	function automatic logic [15:0] frame_build(input logic [7:0] d, input logic seven,
		input logic sync, input logic par_on, input logic odd, input logic mp,
		input logic mpb, input logic two, input logic msbf, input logic inv);
		logic [11:0] f;
		logic [7:0]  o;
		int          pos;
		f   = 12'hFFF;
		o   = msbf ? bit_rev(d) : d;
		o   = inv ? ~o : o;
		if (seven)
			o[7] = 1'b0;
		pos = 0;
		if (!sync)
		begin
			f[0] = 1'b0;
			pos  = 1;
		end
		for (int i = 0; i < 8; i++)
			if (i < 7 || !seven)
				f[pos + i] = o[i];
		pos = pos + (seven ? 7 : 8);
		if (par_on)
		begin
			f[pos] = (^o) ^ odd;
			pos    = pos + 1;
		end
		if (mp)
		begin
			f[pos] = mpb;
			pos    = pos + 1;
		end
		if (!sync)
			pos = pos + (two ? 2 : 1);
		return {pos[3:0], f};
	endfunction

	// ----------------------------------------------------------------
	// Registers and state
	// ----------------------------------------------------------------
	logic [7:0]  rx_hold_q, tx_hold_q, mode_q, ctrl_q, baud_q, baud_cnt_q;
	logic        tx_empty_q, rx_full_q, overrun_q, framing_q, parity_q;
	logic        tx_end_q, mpb_rx_q;
	logic [2:0]  rxd_sync_q, sck_sync_q;
	logic [3:0]  phase_q, tx_sub_q, rx_sub_q, tx_left_q, rx_idx_q;
	logic [11:0] tx_sh_q;
	logic [7:0]  tx_saved_q;
	logic        tx_busy_q, txd_q, retry_q, sck_q;
	logic [8:0]  rx_bits_q;
	logic [4:0]  err_cnt_q;
	scc_pkg::scc_rx_state_t rx_state_q;

	// ----------------------------------------------------------------
	// Mode decode
	// ----------------------------------------------------------------
	logic smart, sync_m, seven, mp, par_on, msbf, inv, ext, two;
	logic tx_en, rx_en;
	logic [3:0] dlen, rx_total;
	assign smart    = mode_q[scc_pkg::MODE_SMART];
	assign sync_m   = mode_q[scc_pkg::MODE_SYNC] & ~smart;
	assign seven    = ~sync_m & ~smart & mode_q[scc_pkg::MODE_CHR7];
	assign mp       = ~sync_m & ~smart & mode_q[scc_pkg::MODE_MULTIPROC];
	assign par_on   = ~sync_m & ~mp & (mode_q[scc_pkg::MODE_PAR_EN] | smart);
	assign two      = mode_q[scc_pkg::MODE_TWO_STOP] | smart;  // Guard time
	assign inv      = smart & ctrl_q[scc_pkg::CTRL_INVERSE];
	assign msbf     = (mode_q[scc_pkg::MODE_MSB_FIRST] & ~seven) | inv;
	assign ext      = ctrl_q[scc_pkg::CTRL_EXT_CLK] & ~smart;
	assign tx_en    = ctrl_q[scc_pkg::CTRL_TX_EN];
	assign rx_en    = ctrl_q[scc_pkg::CTRL_RX_EN];
	assign dlen     = seven ? 4'h7 : 4'h8;
	assign rx_total = dlen + {3'h0, par_on} + {3'h0, mp} + 4'h1;

	// ----------------------------------------------------------------
	// Pin synchronisers; stage 0 feeds only stage 1
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rxd_sync_q <= 3'h7;
			sck_sync_q <= 3'h7;
		end
		else
		begin
			rxd_sync_q <= {rxd_sync_q[1:0], rxd_pin};
			sck_sync_q <= {sck_sync_q[1:0], sck_in};
		end
	end

	logic rxd_lvl, rxd_fall, sck_rise, sck_fall;
	assign rxd_lvl  = rxd_sync_q[1];
	assign rxd_fall = rxd_sync_q[2] & ~rxd_sync_q[1];
	assign sck_rise = sck_sync_q[1] & ~sck_sync_q[2];
	assign sck_fall = sck_sync_q[2] & ~sck_sync_q[1];

	// ----------------------------------------------------------------
	// Clocking: baud divider, sixteenth-bit tick and sync bit clock
	// ----------------------------------------------------------------
	logic int_tick, tick, clk_run, sclk_fall, sclk_rise, tx_bit_end, rx_sample;
	assign int_tick  = (baud_cnt_q == baud_q);
	assign tick      = ext ? sck_rise : int_tick;
	assign clk_run   = sync_m & ~ext & (tx_busy_q | ~tx_empty_q | rx_en);
	assign sclk_fall = ext ? sck_fall : (clk_run & int_tick & phase_q == scc_pkg::SUB_LAST);
	assign sclk_rise = ext ? sck_rise : (clk_run & int_tick & phase_q == scc_pkg::SUB_MID);
	assign tx_bit_end = sync_m ? sclk_fall : (tick & tx_sub_q == scc_pkg::SUB_LAST);
	assign rx_sample  = tick & rx_sub_q == scc_pkg::SUB_MID;

	// Divider runs free so the bit rate never depends on traffic
	always_ff @(posedge clock)
	begin
		if (rst)
			baud_cnt_q <= 8'h00;
		else if (int_tick)
			baud_cnt_q <= 8'h00;
		else
			baud_cnt_q <= baud_cnt_q + 8'h01;
	end

	// Sync clock: low in first half of a bit, idles high
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			phase_q <= scc_pkg::SUB_LAST;
			sck_q   <= 1'b1;
		end
		else
		begin
			if (!clk_run)
				phase_q <= scc_pkg::SUB_LAST;
			else if (int_tick)
				phase_q <= phase_q + 4'h1;
			sck_q <= clk_run ? phase_q[3] : 1'b1;
		end
	end

	assign sck_out = sck_q;
	assign sck_oe  = sync_m & ~ext;

	// ----------------------------------------------------------------
	// Transmitter
	// ----------------------------------------------------------------
	logic        tx_load, tx_done, tx_hold_wr, rx_sample_tx;
	logic [15:0] tx_frame;
	logic [7:0]  tx_src;
	assign tx_hold_wr = reg_wr & reg_addr == scc_pkg::ADDR_TX_HOLD;
	assign tx_done    = tx_busy_q & tx_bit_end & tx_left_q == 4'h1;
	// Resend has priority over fresh data after an error signal
	assign tx_src   = (smart & retry_q) ? tx_saved_q : tx_hold_q;
	assign tx_frame = frame_build(tx_src, seven, sync_m, par_on,
		mode_q[scc_pkg::MODE_PAR_ODD], mp, ctrl_q[scc_pkg::CTRL_MPB_TX], two, msbf, inv);
	assign tx_load  = tx_en & (~tx_empty_q | (smart & retry_q))
		& (sync_m ? sclk_fall : 1'b1) & (~tx_busy_q | tx_done);

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			tx_busy_q  <= 1'b0;
			txd_q      <= 1'b1;
			tx_sh_q    <= 12'hFFF;
			tx_left_q  <= 4'h0;
			tx_sub_q   <= 4'h0;
			tx_saved_q <= 8'h00;
			retry_q    <= 1'b0;
		end
		else
		begin
			if (tick)
				tx_sub_q <= tx_sub_q + 4'h1;
			if (tx_load)
			begin
				tx_busy_q  <= 1'b1;
				txd_q      <= tx_frame[0];
				tx_sh_q    <= {1'b1, tx_frame[11:1]};
				tx_left_q  <= tx_frame[15:12];
				tx_sub_q   <= 4'h0;
				tx_saved_q <= tx_src;
				retry_q    <= 1'b0;
			end
			else if (tx_done || (tx_busy_q && !tx_en))
			begin
				tx_busy_q <= 1'b0;
				txd_q     <= 1'b1;
			end
			else if (tx_busy_q && tx_bit_end)
			begin
				txd_q     <= tx_sh_q[0];
				tx_sh_q   <= {1'b1, tx_sh_q[11:1]};
				tx_left_q <= tx_left_q - 4'h1;
			end
			// Card pulls the line low in the first guard bit on error
			if (smart && tx_busy_q && tx_left_q == 4'h2 && rx_sample_tx && !rxd_lvl)
				retry_q <= 1'b1;
		end
	end

	assign rx_sample_tx = tick & tx_sub_q == scc_pkg::SUB_MID;

	// Error signal overrides the line while it is driven
	assign txd_pin = txd_q & (err_cnt_q == 5'h00);

	// ----------------------------------------------------------------
	// Receiver
	// ----------------------------------------------------------------
	logic       rx_done, par_err, frame_err;
	logic [7:0] rx_line, rx_data;
	// Clocked mode: the eighth bit lands on the completing edge, so take it live
	assign rx_line = sync_m ? {rxd_lvl, rx_bits_q[6:0]}
		: (seven ? {1'b0, rx_bits_q[6:0]} : rx_bits_q[7:0]);
	assign rx_data = msbf ? bit_rev(inv ? ~rx_line : rx_line) : (inv ? ~rx_line : rx_line);
	assign par_err = par_on & ((^rx_line) ^ rx_bits_q[dlen] ^ mode_q[scc_pkg::MODE_PAR_ODD]);
	// Stop is sampled live at completion; only the first is checked
	assign frame_err = ~sync_m & ~rxd_lvl;
	assign rx_done = sync_m ? (rx_en & sclk_rise & rx_idx_q == 4'h7)
		: (rx_state_q == scc_pkg::SCC_RX_FRAME & rx_sample & rx_idx_q == rx_total);

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rx_state_q <= scc_pkg::SCC_RX_IDLE;
			rx_idx_q   <= 4'h0;
			rx_sub_q   <= 4'h0;
			rx_bits_q  <= 9'h000;
		end
		else if (!rx_en)
		begin
			rx_state_q <= scc_pkg::SCC_RX_IDLE;
			rx_idx_q   <= 4'h0;
		end
		else if (sync_m)
		begin
			if (sclk_rise)
			begin
				rx_bits_q[rx_idx_q[2:0]] <= rxd_lvl;
				rx_idx_q <= (rx_idx_q >= 4'h7) ? 4'h0 : rx_idx_q + 4'h1;
			end
		end
		else
		begin
			if (tick)
				rx_sub_q <= rx_sub_q + 4'h1;
			unique case (rx_state_q)
				scc_pkg::SCC_RX_IDLE:
					if (rxd_fall)
					begin
						rx_state_q <= scc_pkg::SCC_RX_FRAME;
						rx_sub_q   <= 4'h0;
						rx_idx_q   <= 4'h0;
					end
				scc_pkg::SCC_RX_FRAME:
					if (rx_sample)
					begin
						if (rx_idx_q == 4'h0 && rxd_lvl)
							rx_state_q <= scc_pkg::SCC_RX_IDLE;            // False start
						else if (rx_done)
							rx_state_q <= scc_pkg::SCC_RX_IDLE;
						else
						begin
							if (rx_idx_q != 4'h0)
								rx_bits_q[rx_idx_q - 4'h1] <= rxd_lvl;
							rx_idx_q <= rx_idx_q + 4'h1;
						end
					end
			endcase
		end
	end

	// Smart card error signal lasts one bit time
	always_ff @(posedge clock)
	begin
		if (rst)
			err_cnt_q <= 5'h00;
		else if (rx_done && smart && par_err)
			err_cnt_q <= scc_pkg::ERR_TICKS;
		else if (tick && err_cnt_q != 5'h00)
			err_cnt_q <= err_cnt_q - 5'h01;
	end

	// ----------------------------------------------------------------
	// Holding registers and flags; hardware set wins over clear
	// ----------------------------------------------------------------
	logic rx_hold_rd, stat_wr;
	assign rx_hold_rd = reg_rd & reg_addr == scc_pkg::ADDR_RX_HOLD;
	assign stat_wr    = reg_wr & reg_addr == scc_pkg::ADDR_STATUS;

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			rx_hold_q <= scc_pkg::RX_HOLD_RESET;
			rx_full_q <= 1'b0;
			overrun_q <= 1'b0;
			framing_q <= 1'b0;
			parity_q  <= 1'b0;
			mpb_rx_q  <= 1'b0;
		end
		else
		begin
			if (rx_hold_rd)
				rx_full_q <= 1'b0;
			if (stat_wr && !reg_wdata[scc_pkg::STAT_OVERRUN])
				overrun_q <= 1'b0;
			if (stat_wr && !reg_wdata[scc_pkg::STAT_FRAMING])
				framing_q <= 1'b0;
			if (stat_wr && !reg_wdata[scc_pkg::STAT_PARITY])
				parity_q <= 1'b0;
			if (rx_done)
			begin
				if (rx_full_q && !rx_hold_rd)
					overrun_q <= 1'b1;
				else
				begin
					rx_hold_q <= rx_data;
					rx_full_q <= 1'b1;
					mpb_rx_q  <= mp & rx_bits_q[dlen];
					if (frame_err)
						framing_q <= 1'b1;
					if (par_err)
						parity_q <= 1'b1;
				end
			end
		end
	end

	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			tx_hold_q  <= scc_pkg::TX_HOLD_RESET;
			tx_empty_q <= 1'b1;
			tx_end_q   <= 1'b1;
		end
		else
		begin
			if (tx_hold_wr)
			begin
				tx_hold_q  <= reg_wdata;
				tx_empty_q <= 1'b0;
				tx_end_q   <= 1'b0;
			end
			if (tx_load && !(smart && retry_q))
				tx_empty_q <= 1'b1;
			if (tx_done && !tx_load)
				tx_end_q <= 1'b1;
		end
	end

	// ----------------------------------------------------------------
	// Configuration registers and read port
	// ----------------------------------------------------------------
	always_ff @(posedge clock)
	begin
		if (rst)
		begin
			mode_q <= scc_pkg::MODE_RESET;
			ctrl_q <= scc_pkg::CTRL_RESET;
			baud_q <= scc_pkg::BAUD_RESET;
		end
		else if (reg_wr)
		begin
			unique case (reg_addr)
				scc_pkg::ADDR_MODE: mode_q <= reg_wdata;
				scc_pkg::ADDR_CTRL: ctrl_q <= reg_wdata;
				scc_pkg::ADDR_BAUD: baud_q <= reg_wdata;
				default:            ;
			endcase
		end
	end

	logic [7:0] status;
	assign status = {tx_empty_q, rx_full_q, overrun_q, framing_q, parity_q,
		tx_end_q, rxd_lvl, mpb_rx_q};

	// Read data stands in the cycle after the strobe only
	always_ff @(posedge clock)
	begin
		if (rst || !reg_rd)
			reg_rdata <= 8'h00;
		else
		begin
			unique case (reg_addr)
				scc_pkg::ADDR_RX_HOLD: reg_rdata <= rx_hold_q;
				scc_pkg::ADDR_TX_HOLD: reg_rdata <= tx_hold_q;
				scc_pkg::ADDR_MODE:    reg_rdata <= mode_q;
				scc_pkg::ADDR_CTRL:    reg_rdata <= ctrl_q;
				scc_pkg::ADDR_STATUS:  reg_rdata <= status;
				scc_pkg::ADDR_BAUD:    reg_rdata <= baud_q;
				default:               reg_rdata <= 8'h00;
			endcase
		end
	end

	// ----------------------------------------------------------------
	// Requests; both paths run side by side
	// ----------------------------------------------------------------
	assign irq_tx_empty = ctrl_q[scc_pkg::CTRL_TX_IE] & tx_empty_q;
	assign irq_tx_end   = ctrl_q[scc_pkg::CTRL_TEND_IE] & tx_end_q;
	assign irq_rx_full  = ctrl_q[scc_pkg::CTRL_RX_IE] & rx_full_q;
	assign irq_rx_err   = ctrl_q[scc_pkg::CTRL_RX_IE] & (overrun_q | framing_q | parity_q);
	assign dma_tx_req   = tx_en & tx_empty_q;
	assign dma_rx_req   = rx_en & rx_full_q;

endmodule

`default_nettype wire

// file: scc_pkg.sv
// Constants shared by the serial communication channel.
// Assumes a single 200 MHz clock and an 8-bit register port.
package scc_pkg;

	// ----------------------------------------------------------------
	// Register map
	// ----------------------------------------------------------------
	localparam int          ADDR_W         = 3;
	localparam int          DATA_W         = 8;
	localparam logic [2:0]  ADDR_RX_HOLD   = 3'h0;
	localparam logic [2:0]  ADDR_TX_HOLD   = 3'h1;
	localparam logic [2:0]  ADDR_MODE      = 3'h2;
	localparam logic [2:0]  ADDR_CTRL      = 3'h3;
	localparam logic [2:0]  ADDR_STATUS    = 3'h4;
	localparam logic [2:0]  ADDR_BAUD      = 3'h5;

	// ----------------------------------------------------------------
	// Reset values
	// ----------------------------------------------------------------
	localparam logic [7:0]  RX_HOLD_RESET  = 8'h00;
	localparam logic [7:0]  TX_HOLD_RESET  = 8'hFF;
	localparam logic [7:0]  MODE_RESET     = 8'h00;
	localparam logic [7:0]  CTRL_RESET     = 8'h00;
	localparam logic [7:0]  BAUD_RESET     = 8'h00;

	// ----------------------------------------------------------------
	// Mode register fields
	// ----------------------------------------------------------------
	localparam int          MODE_SYNC      = 7;
	localparam int          MODE_CHR7      = 6;
	localparam int          MODE_PAR_EN    = 5;
	localparam int          MODE_PAR_ODD   = 4;
	localparam int          MODE_TWO_STOP  = 3;
	localparam int          MODE_MULTIPROC = 2;
	localparam int          MODE_MSB_FIRST = 1;
	localparam int          MODE_SMART     = 0;

	// ----------------------------------------------------------------
	// Control register fields
	// ----------------------------------------------------------------
	localparam int          CTRL_TX_IE     = 7;
	localparam int          CTRL_RX_IE     = 6;
	localparam int          CTRL_TX_EN     = 5;
	localparam int          CTRL_RX_EN     = 4;
	localparam int          CTRL_MPB_TX    = 3;
	localparam int          CTRL_TEND_IE   = 2;
	localparam int          CTRL_INVERSE   = 1;
	localparam int          CTRL_EXT_CLK   = 0;

	// ----------------------------------------------------------------
	// Status register fields
	// ----------------------------------------------------------------
	localparam int          STAT_TX_EMPTY  = 7;
	localparam int          STAT_RX_FULL   = 6;
	localparam int          STAT_OVERRUN   = 5;
	localparam int          STAT_FRAMING   = 4;
	localparam int          STAT_PARITY    = 3;
	localparam int          STAT_TX_END    = 2;
	localparam int          STAT_RXD_LEVEL = 1;
	localparam int          STAT_MPB_RX    = 0;

	// ----------------------------------------------------------------
	// Timing: ticks per bit and the mid-bit sample point
	// ----------------------------------------------------------------
	localparam logic [3:0]  SUB_LAST       = 4'hF;
	localparam logic [3:0]  SUB_MID        = 4'h7;
	localparam logic [4:0]  ERR_TICKS      = 5'h10;

	typedef enum logic {SCC_RX_IDLE, SCC_RX_FRAME} scc_rx_state_t;

endpackage

// file: scc_channel_asserts.sv
// Checker for the serial channel: register port and transmit line.
// Assumes it is bound to scc_channel and sees only its ports.
`timescale 1ns/1ps
`default_nettype none

module scc_channel_asserts
(
	input wire logic       clock,
	input wire logic       rst,
	input wire logic [2:0] reg_addr,
	input wire logic       reg_wr,
	input wire logic       reg_rd,
	input wire logic [7:0] reg_rdata,
	input wire logic       txd_pin,
	input wire logic       sck_oe,
	input wire logic       irq_tx_end,
	input wire logic       dma_tx_req,
	input wire logic       dma_rx_req
);
	// ------
	// Properties
	// ------
	default clocking cb @(posedge clock);
	endclocking
	default disable iff (rst);

	// Holding read, which also clears the full flag
	logic rx_read;
	assign rx_read = reg_rd && reg_addr == scc_pkg::ADDR_RX_HOLD;

	// New byte written while the transmitter is enabled and idle; the clocked
	// link loads only on its own falling clock; only its internally clocked form is left out here
	sequence s_idle_tx_write;
		reg_wr && reg_addr == scc_pkg::ADDR_TX_HOLD && dma_tx_req && irq_tx_end && !sck_oe;
	endsequence
	// Empty flag drops, then returns once the byte moves on
	sequence s_empty_blink;
		!dma_tx_req ##1 dma_tx_req;
	endsequence

	a_rdata_idle_zero: assert property (!reg_rd |=> reg_rdata == 8'h00)
		else $error("read data not zero outside a read slot");
	a_reset_line_idle: assert property ($fell(rst) |-> txd_pin && !sck_oe && !dma_rx_req)
		else $error("line not idle after reset");
	a_tx_start_soon: assert property (s_idle_tx_write |-> ##[1:3] !txd_pin)
		else $error("start bit late after transmit write");
	a_tx_empty_blink: assert property (s_idle_tx_write |=> s_empty_blink)
		else $error("empty flag did not reload");
	a_bit_min_width: assert property ($fell(txd_pin) |-> !txd_pin [*8])
		else $error("low bit shorter than eight clocks");
	a_rx_full_holds: assert property (dma_rx_req && !rx_read && !reg_wr |=> dma_rx_req)
		else $error("receive full dropped without a read");
	a_rx_read_clears: assert property (rx_read && dma_rx_req |=> !dma_rx_req)
		else $error("receive full stayed after a read");
	a_status_full: assert property (reg_rd && reg_addr == scc_pkg::ADDR_STATUS
		&& dma_rx_req |=> reg_rdata[scc_pkg::STAT_RX_FULL])
		else $error("status full bit differs from request");
endmodule

bind scc_channel scc_channel_asserts chk
(
	.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wr(reg_wr), .reg_rd(reg_rd),
	.reg_rdata(reg_rdata), .txd_pin(txd_pin), .sck_oe(sck_oe), .irq_tx_end(irq_tx_end),
	.dma_tx_req(dma_tx_req), .dma_rx_req(dma_rx_req)
);
`default_nettype wire

// file: scc_remote.sv
// Remote serial device: drives frames in, captures frames out.
// Assumes one shared clock and 16 clocks per bit.
`timescale 1ns/1ps
`default_nettype none

module scc_remote
(
	input  wire logic clock,
	input  wire logic txd_pin,
	output var logic  rxd_pin
);
	// ------
	// Line driver and capture
	// ------
	// Released line is pulled high
	initial rxd_pin = 1'b1;

	// Sends n bits, first element first; the last level stays on the line,
	// so back-to-back frames never assign the line twice in one step
	task automatic send(input logic [11:0] bits, input int n);
		for (int i = 0; i < n; i++)
		begin
			rxd_pin <= bits[i];
			repeat (16) @(posedge clock);
		end
	endtask

	// Bounded wait for a start bit; returns at the last mid-bit so back-to-back frames align
	task automatic get_frame(output logic [11:0] bits, input int n, input int lim);
		bits = 12'hFFF;
		for (int i = 0; i < lim && txd_pin; i++)
			@(posedge clock);
		if (!txd_pin)
		begin
			repeat (7) @(posedge clock);
			for (int i = 0; i < n; i++)
			begin
				bits[i] = txd_pin;
				if (i < n - 1)
					repeat (16) @(posedge clock);
			end
		end
	endtask
endmodule
`default_nettype wire

// file: test_serial_comm_channel.sv
// Self-checking bench for the serial channel.
// Assumes the channel, its checker and the remote model are compiled first.
`timescale 1ns/1ps
`default_nettype none

module test_serial_comm_channel;
	logic        clock = 1'b0;
	logic        rst = 1'b1;
	logic [2:0]  reg_addr = 3'h0;
	logic [7:0]  reg_wdata = 8'h00;
	logic        reg_wr = 1'b0;
	logic        reg_rd = 1'b0;
	logic [7:0]  reg_rdata;
	logic        rxd_pin;
	logic        txd_pin;
	logic        sck_out;
	logic        irq_tx_end;
	logic        irq_tx_empty;
	logic        irq_rx_full;
	logic        irq_rx_err;
	int          errors = 0;
	int          num_checks = 0;
	logic [11:0] fr;
	logic [11:0] ex;
	int          n;
	logic [7:0]  rd;

	// ------
	// Harness
	// ------
	always #2.5 clock = ~clock;

	// External clock pin held idle: only the internal baud source is used
	scc_channel DUT
	(
		.clock(clock), .rst(rst), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
		.reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata), .rxd_pin(rxd_pin),
		.txd_pin(txd_pin), .sck_in(1'b1), .sck_out(sck_out), .sck_oe(),
		.irq_tx_end(irq_tx_end), .irq_tx_empty(irq_tx_empty), .irq_rx_full(irq_rx_full),
		.irq_rx_err(irq_rx_err), .dma_tx_req(), .dma_rx_req()
	);
	scc_remote remote (.clock(clock), .txd_pin(txd_pin), .rxd_pin(rxd_pin));

	// Verdict and end of run
	task automatic report_and_stop();
		$display("checks %0d mismatches %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0)
			$display("Finished cleanly");
		else
			$display("Finished with errors");
		$finish;
	endtask

	// Frame compare; bytes go through the same path
	task automatic check(input logic [11:0] got, input logic [11:0] exp);
		num_checks++;
		if (got !== exp)
		begin
			errors++;
			$display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
		end
	endtask
	task automatic check8(input logic [7:0] got, input logic [7:0] exp);
		check({4'h0, got}, {4'h0, exp});
	endtask

	// Register port: one-cycle strobes launched just after an edge
	task automatic reg_write(input logic [2:0] a, input logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge clock);
		reg_wr <= 1'b0;
	endtask
	task automatic reg_read(input logic [2:0] a, output logic [7:0] d);
		@(posedge clock);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge clock);
		reg_rd <= 1'b0;
		#1 d = reg_rdata;
	endtask

	// Expected wire bits for a mode byte and data, start bit first
	function automatic void build(input logic [7:0] m, input logic [7:0] d,
		output logic [11:0] b, output int k);
		int   nb;
		logic p;
		nb = m[scc_pkg::MODE_CHR7] ? 7 : 8;
		p = m[scc_pkg::MODE_PAR_ODD];
		b = 12'hFFF;
		b[0] = 1'b0;
		k = 1;
		for (int i = 0; i < nb; i++)
		begin
			b[k] = (m[scc_pkg::MODE_MSB_FIRST] && nb == 8) ? d[7 - i] : d[i];
			p = p ^ b[k];
			k++;
		end
		if (m[scc_pkg::MODE_MULTIPROC] || m[scc_pkg::MODE_PAR_EN])
		begin
			b[k] = m[scc_pkg::MODE_MULTIPROC] ? 1'b0 : p;
			k++;
		end
		k = k + (m[scc_pkg::MODE_TWO_STOP] ? 2 : 1);
	endfunction

	// ------
	// Scenarios
	// ------
	task automatic t_reset_regs();
		reg_read(scc_pkg::ADDR_RX_HOLD, rd);
		check8(rd, 8'h00);
		reg_read(scc_pkg::ADDR_STATUS, rd);
		check8(rd, 8'h86);
		reg_read(scc_pkg::ADDR_TX_HOLD, rd);
		check8(rd, 8'hFF);
		reg_write(scc_pkg::ADDR_RX_HOLD, 8'h5A);
		reg_read(scc_pkg::ADDR_RX_HOLD, rd);
		check8(rd, 8'h00);
		reg_read(3'h6, rd);
		check8(rd, 8'h00);
		reg_write(scc_pkg::ADDR_CTRL, 8'h34);
	endtask

	// Second byte queued while the first shifts must follow with no gap
	task automatic t_tx_back_to_back();
		build(8'h00, 8'hA5, ex, n);
		reg_write(scc_pkg::ADDR_TX_HOLD, 8'hA5);
		fork
			remote.get_frame(fr, 10, 20);
			begin
				repeat (4) @(posedge clock);
				reg_write(scc_pkg::ADDR_TX_HOLD, 8'h3C);
			end
		join
		check(fr, ex);
		build(8'h00, 8'h3C, ex, n);
		remote.get_frame(fr, 10, 12);
		check(fr, ex);
		repeat (16) @(posedge clock);
	endtask

	task automatic t_tx_formats();
		logic [7:0] modes [5] = '{8'h68, 8'h30, 8'h02, 8'h42, 8'h24};
		foreach (modes[i])
		begin
			reg_write(scc_pkg::ADDR_MODE, modes[i]);
			build(modes[i], 8'hB3, ex, n);
			reg_write(scc_pkg::ADDR_TX_HOLD, 8'hB3);
			remote.get_frame(fr, n, 20);
			check(fr, ex);
			repeat (24) @(posedge clock);
		end
	endtask

	// Two frames in while one goes out; then parity and framing faults
	task automatic t_rx_errors();
		logic [11:0] f1;
		logic [11:0] f2;
		int          k;
		reg_write(scc_pkg::ADDR_MODE, 8'h00);
		build(8'h00, 8'h11, f1, k);
		build(8'h00, 8'h22, f2, k);
		build(8'h00, 8'h5A, ex, n);
		reg_write(scc_pkg::ADDR_TX_HOLD, 8'h5A);
		fork
			begin
				remote.send(f1, 10);
				remote.send(f2, 10);
			end
			remote.get_frame(fr, 10, 20);
		join
		check(fr, ex);
		reg_read(scc_pkg::ADDR_STATUS, rd);
		check8(rd & 8'h78, 8'h60);
		// All four requests enabled: full, error, empty and end all stand
		reg_write(scc_pkg::ADDR_CTRL, 8'hF4);
		@(posedge clock);
		check8({4'h0, irq_tx_end, irq_tx_empty, irq_rx_full, irq_rx_err}, 8'h0F);
		reg_read(scc_pkg::ADDR_RX_HOLD, rd);
		check8(rd, 8'h11);
		reg_write(scc_pkg::ADDR_STATUS, 8'h00);
		@(posedge clock);
		check8({4'h0, irq_tx_end, irq_tx_empty, irq_rx_full, irq_rx_err}, 8'h0C);
		reg_write(scc_pkg::ADDR_MODE, 8'h20);
		build(8'h20, 8'h01, f1, k);
		f1[9] = ~f1[9];
		remote.send(f1, k);
		reg_read(scc_pkg::ADDR_STATUS, rd);
		check8(rd & 8'h78, 8'h48);
		reg_read(scc_pkg::ADDR_RX_HOLD, rd);
		reg_write(scc_pkg::ADDR_STATUS, 8'h00);
		reg_write(scc_pkg::ADDR_MODE, 8'h00);
		build(8'h00, 8'h55, f1, k);
		f1[9] = 1'b0;
		remote.send(f1, k);
		reg_read(scc_pkg::ADDR_STATUS, rd);
		check8(rd & 8'h7A, 8'h50);
		reg_read(scc_pkg::ADDR_RX_HOLD, rd);
		check8(rd, 8'h55);
		remote.send(12'hFFF, 1);
	endtask

	// Clocked mode: eight bits, no framing, each taken at a rising link clock
	task automatic t_sync();
		logic [7:0] got;
		got = 8'h00;
		reg_write(scc_pkg::ADDR_MODE, 8'h80);
		reg_write(scc_pkg::ADDR_TX_HOLD, 8'hC6);
		for (int i = 0; i < 40 && txd_pin; i++)
			@(posedge clock);
		for (int i = 0; i < 8; i++)
		begin
			@(posedge sck_out);
			got[i] = txd_pin;
		end
		check8(got, 8'hC6);
	endtask

	// Main sequence: reset for 10 clocks, then each scenario
	initial
	begin
		repeat (10) @(posedge clock);
		rst <= 1'b0;
		t_reset_regs();
		t_tx_back_to_back();
		t_tx_formats();
		t_rx_errors();
		t_sync();
		report_and_stop();
	end

	// Watchdog: the run needs about 2200 clocks, so 10000 means a hang
	initial
	begin
		repeat (10000) @(posedge clock);
		errors++;
		report_and_stop();
	end
endmodule
`default_nettype wire
